// [core/msp_pkg.sv]
// Purpose: constants for the memory map and page logic
// Assumes: 8-bit data paths, 16-bit code addresses
// Notes:   offsets are direct-mode special register addresses
package msp_pkg;
    localparam logic [15:0] MSP_FLASH_BASE      = 16'h0000;
    localparam logic [15:0] MSP_FLASH_TOP_LARGE = 16'h7bff;
    localparam logic [15:0] MSP_FLASH_TOP_SMALL = 16'h3fff;
    localparam logic [7:0]  MSP_SFR_BASE        = 8'h80;
    localparam logic [7:0]  MSP_BANK_TOP        = 8'h1f;
    localparam logic [7:0]  MSP_BITRAM_BASE     = 8'h20;
    localparam logic [7:0]  MSP_BITRAM_TOP      = 8'h2f;
    localparam logic [7:0]  MSP_ADDR_SP         = 8'h81;
    localparam logic [7:0]  MSP_ADDR_PAGE_SEC   = 8'h85;
    localparam logic [7:0]  MSP_ADDR_PAGE_BOT   = 8'h86;
    localparam logic [7:0]  MSP_ADDR_PAGE_SEL   = 8'ha7;
    localparam logic [7:0]  MSP_ADDR_PAGE_CTL   = 8'he5;
    localparam logic [7:0]  MSP_ADDR_PSW        = 8'hd0;
    localparam logic [7:0]  MSP_ADDR_PROGRAM_STORE_CONTROL      = 8'h8f;
    localparam logic [7:0]  MSP_ADDR_PORT0      = 8'h80;
    localparam logic [7:0]  MSP_ADDR_PORT1      = 8'h90;
    localparam logic [7:0]  MSP_ADDR_PORT2      = 8'ha0;
    localparam logic [7:0]  MSP_ADDR_PORT3      = 8'hb0;
    localparam logic [7:0]  MSP_PAGE_0          = 8'h00;
    localparam logic [7:0]  MSP_PAGE_F          = 8'h0f;
    localparam logic [7:0]  MSP_SP_RESET        = 8'h07;
    localparam logic [7:0]  MSP_PAGE_CTL_RESET  = 8'h01;
    localparam logic [7:0]  MSP_PAGE_RESET      = 8'h00;
    localparam int          MSP_RS0_BIT         = 3;
    localparam int          MSP_RS1_BIT         = 4;
    localparam int          MSP_PSWE_BIT        = 0;
    localparam int          MSP_AUTOPG_BIT      = 0;
    localparam int          MSP_REC_W           = 32;
    localparam logic [5:0]  MSP_REC_MAX         = 6'd32;
    typedef enum logic [2:0] {
        MSP_SPACE_RAM  = 3'b001,
        MSP_SPACE_SFR  = 3'b010,
        MSP_SPACE_UPR  = 3'b100
    } msp_space_t;
endpackage

// [core/msp_page_stack.sv]
// Purpose: three-byte special register page stack
// Assumes: single-cycle entry and return strobes from the core
// Notes:   software writes touch one byte only
`timescale 1ns/1ps
`default_nettype none
module msp_page_stack
    import msp_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // core events
    input  wire logic       irq_entry,
    input  wire logic       irq_return,
    input  wire logic       auto_page_enable,
    // software writes
    input  wire logic       wr_sel,
    input  wire logic       wr_sec,
    input  wire logic       wr_bot,
    input  wire logic [7:0] wr_data,
    // stack contents
    output logic      [7:0] page_select,
    output logic      [7:0] page_stack_second,
    output logic      [7:0] page_stack_bottom
);
    logic push;
    logic pop;
    assign push = irq_entry & auto_page_enable;
    assign pop  = irq_return & auto_page_enable & ~irq_entry;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            page_select       <= MSP_PAGE_RESET;
            page_stack_second <= MSP_PAGE_RESET;
            page_stack_bottom <= MSP_PAGE_RESET;
        end else if (push) begin
            page_select       <= MSP_PAGE_0;
            page_stack_second <= page_select;
            page_stack_bottom <= page_stack_second;
        end else if (pop) begin
            page_select       <= page_stack_second;
            page_stack_second <= page_stack_bottom;
            page_stack_bottom <= MSP_PAGE_RESET;
        end else begin
            if (wr_sel) page_select <= wr_data;
            if (wr_sec) page_stack_second <= wr_data;
            if (wr_bot) page_stack_bottom <= wr_data;
        end
    end
endmodule
`default_nettype wire

// [core/msp_memmap.sv]
// Purpose: memory space decode, stack pointer, stack record, page select
// Assumes: core gives access kind, address mode and strobes each cycle
// Notes:   one access per cycle; special registers outside this block
//          are reached through the decoded select outputs
`timescale 1ns/1ps
`default_nettype none
module msp_memmap
    import msp_pkg::*;
#(
    parameter bit LARGE_FLASH = 1'b1
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // code space access
    input  wire logic [15:0] code_addr,
    input  wire logic        code_fetch,
    input  wire logic        xdata_wr,
    output logic             code_valid,
    output logic             code_reserved,
    output logic             code_write,
    // data space access
    input  wire logic [7:0]  data_addr,
    input  wire logic        data_indirect,
    input  wire logic        data_use_r1,
    input  wire logic        data_bit,
    input  wire logic        data_wr,
    input  wire logic [7:0]  data_wdata,
    input  wire logic [7:0]  reg_r0,
    input  wire logic [7:0]  reg_r1,
    output logic      [7:0]  ram_addr,
    output logic             ram_sel,
    output logic      [2:0]  ram_bit,
    output logic             ram_bit_mode,
    output logic             sfr_sel,
    output logic      [7:0]  sfr_addr,
    output logic      [7:0]  sfr_page,
    output logic             sfr_bit_mode,
    output logic             bit_illegal,
    output logic      [7:0]  local_rdata,
    output logic             local_hit,
    // stack events
    input  wire logic        stk_push,
    input  wire logic        stk_pop,
    input  wire logic        stk_call,
    input  wire logic        stk_ret,
    output logic      [7:0]  stack_top_pointer,
    output logic      [7:0]  stack_wr_addr,
    // debug record
    output logic [MSP_REC_W-1:0] rec_shift,
    output logic             rec_overflow,
    output logic             rec_underflow,
    // interrupt events
    input  wire logic        irq_entry,
    input  wire logic        irq_return,
    // status word and store control
    input  wire logic [7:0]  program_status_word,
    input  wire logic [7:0]  program_store_control,
    output logic             auto_page_enable
);
    logic [7:0] page_select;
    logic [7:0] page_stack_second;
    logic [7:0] page_stack_bottom;
    logic [7:0] sp_reg;
    logic [7:0] ctl_reg;
    logic [5:0] depth_reg;
    logic [7:0] eff_addr;
    logic [1:0] bank;
    logic       direct_sfr;
    logic       wr_sp;
    logic       wr_sel;
    logic       wr_sec;
    logic       wr_bot;
    logic       wr_ctl;
    logic       all_page;

    function automatic logic is_all_page(input logic [7:0] a);
        is_all_page = (a == MSP_ADDR_PORT0) || (a == MSP_ADDR_PORT1) ||
                      (a == MSP_ADDR_PORT2) || (a == MSP_ADDR_PORT3) ||
                      (a == MSP_ADDR_SP) || (a == MSP_ADDR_PAGE_SEL) ||
                      (a == MSP_ADDR_PAGE_SEC) ||
                      (a == MSP_ADDR_PAGE_BOT);
    endfunction

    function automatic logic sfr_bit_ok(input logic [7:0] a);
        sfr_bit_ok = (a[2:0] == 3'h0);
    endfunction

    // code space
    always_comb begin
        logic [15:0] top;
        top = LARGE_FLASH ? MSP_FLASH_TOP_LARGE : MSP_FLASH_TOP_SMALL;
        // data writes steered into code only with store enable
        code_write = xdata_wr &
                     program_store_control[MSP_PSWE_BIT];
        code_reserved = (code_addr > top);
        code_valid    = (code_fetch | code_write) &
                        (code_addr >= MSP_FLASH_BASE) & ~code_reserved;
    end

    // data space decode
    assign bank = {program_status_word[MSP_RS1_BIT],
                   program_status_word[MSP_RS0_BIT]};
    assign eff_addr = data_indirect ?
                      (data_use_r1 ? reg_r1 : reg_r0) : data_addr;
    assign direct_sfr = ~data_indirect & ~data_bit &
                        (data_addr >= MSP_SFR_BASE);

    always_comb begin
        ram_addr     = eff_addr;
        ram_bit      = 3'h0;
        ram_bit_mode = 1'b0;
        sfr_bit_mode = 1'b0;
        bit_illegal  = 1'b0;
        sfr_addr     = data_addr;
        sfr_sel      = direct_sfr;
        if (data_bit) begin
            if (data_addr < MSP_SFR_BASE) begin
                ram_addr = MSP_BITRAM_BASE +
                           {4'h0, data_addr[6:3]};
                ram_bit  = data_addr[2:0];
                ram_bit_mode = 1'b1;
            end else begin
                sfr_addr = {data_addr[7:3], 3'h0};
                sfr_sel  = sfr_bit_ok({data_addr[7:3], 3'h0});
                sfr_bit_mode = sfr_sel;
                bit_illegal  = ~sfr_sel;
            end
        end else if (~data_indirect && data_addr <= MSP_BANK_TOP) begin
            ram_addr = {3'h0, bank, data_addr[2:0]};
        end
        ram_sel = ~sfr_sel & ~bit_illegal;
    end

    assign all_page = is_all_page(sfr_addr);
    assign sfr_page = all_page ? MSP_PAGE_0 : page_select;

    // local register writes
    assign wr_sp  = data_wr & direct_sfr & (data_addr == MSP_ADDR_SP);
    assign wr_sel = data_wr & direct_sfr &
                    (data_addr == MSP_ADDR_PAGE_SEL);
    assign wr_sec = data_wr & direct_sfr &
                    (data_addr == MSP_ADDR_PAGE_SEC);
    assign wr_bot = data_wr & direct_sfr & (data_addr == MSP_ADDR_PAGE_BOT);
    assign wr_ctl = data_wr & direct_sfr & (page_select == MSP_PAGE_F) &
                    (data_addr == MSP_ADDR_PAGE_CTL);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctl_reg <= MSP_PAGE_CTL_RESET;
        end else if (wr_ctl) begin
            ctl_reg <= {7'h00, data_wdata[MSP_AUTOPG_BIT]};
        end
    end
    assign auto_page_enable = ctl_reg[MSP_AUTOPG_BIT];

    // stack pointer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sp_reg <= MSP_SP_RESET;
        end else if (wr_sp) begin
            sp_reg <= data_wdata;
        end else if (stk_call) begin
            sp_reg <= sp_reg + 8'h02;
        end else if (stk_ret) begin
            sp_reg <= sp_reg - 8'h02;
        end else if (stk_push) begin
            sp_reg <= sp_reg + 8'h01;
        end else if (stk_pop) begin
            sp_reg <= sp_reg - 8'h01;
        end
    end
    assign stack_top_pointer = sp_reg;
    assign stack_wr_addr     = sp_reg + 8'h01;

    // stack record, depth tracked alongside the shift register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rec_shift     <= '0;
            depth_reg     <= 6'd0;
            rec_overflow  <= 1'b0;
            rec_underflow <= 1'b0;
        end else if (stk_call) begin
            rec_shift <= {rec_shift[MSP_REC_W-3:0], 2'b11};
            if (depth_reg >= MSP_REC_MAX - 6'd1) begin
                rec_overflow <= 1'b1;
                depth_reg    <= MSP_REC_MAX;
            end else begin
                depth_reg <= depth_reg + 6'd2;
            end
        end else if (stk_ret) begin
            rec_shift <= {2'b00, rec_shift[MSP_REC_W-1:2]};
            if (depth_reg < 6'd2) begin
                rec_underflow <= 1'b1;
                depth_reg     <= 6'd0;
            end else begin
                depth_reg <= depth_reg - 6'd2;
            end
        end else if (stk_push | (wr_sp & (data_wdata == sp_reg + 8'h01))) begin
            rec_shift <= {rec_shift[MSP_REC_W-2:0], 1'b0};
            if (depth_reg == MSP_REC_MAX) begin
                rec_overflow <= 1'b1;
            end else begin
                depth_reg <= depth_reg + 6'd1;
            end
        end else if (stk_pop | (wr_sp & (data_wdata == sp_reg - 8'h01))) begin
            rec_shift <= {1'b0, rec_shift[MSP_REC_W-1:1]};
            if (depth_reg == 6'd0) begin
                rec_underflow <= 1'b1;
            end else begin
                depth_reg <= depth_reg - 6'd1;
            end
        end
    end

    // page stack
    msp_page_stack u_page_stack (
        .clk               (clk),
        .reset             (reset),
        .irq_entry         (irq_entry),
        .irq_return        (irq_return),
        .auto_page_enable  (auto_page_enable),
        .wr_sel            (wr_sel),
        .wr_sec            (wr_sec),
        .wr_bot            (wr_bot),
        .wr_data           (data_wdata),
        .page_select       (page_select),
        .page_stack_second (page_stack_second),
        .page_stack_bottom (page_stack_bottom)
    );

    // local register reads
    always_comb begin
        local_hit   = direct_sfr;
        local_rdata = 8'h00;
        case (data_addr)
            MSP_ADDR_SP:       local_rdata = sp_reg;
            MSP_ADDR_PAGE_SEL: local_rdata = page_select;
            MSP_ADDR_PAGE_SEC: local_rdata = page_stack_second;
            MSP_ADDR_PAGE_BOT: local_rdata = page_stack_bottom;
            MSP_ADDR_PAGE_CTL: begin
                local_rdata = ctl_reg;
                local_hit   = direct_sfr & (page_select == MSP_PAGE_F);
            end
            default:           local_hit = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// [testbench/msp_memmap_checker.sv]
// Purpose: port checks for decode and stack pointer
// Assumes: bound to msp_memmap
// Notes:   single clock domain
`timescale 1ns/1ps
`default_nettype none
module msp_memmap_checker
    import msp_pkg::*;
#(
    parameter bit LARGE_FLASH = 1'b1
)
(
    // clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // watched inputs
    input wire logic [15:0] code_addr,
    input wire logic        code_fetch,
    input wire logic        xdata_wr,
    input wire logic [7:0]  data_addr,
    input wire logic        data_indirect,
    input wire logic        data_use_r1,
    input wire logic        data_bit,
    input wire logic        data_wr,
    input wire logic [7:0]  reg_r0,
    input wire logic [7:0]  reg_r1,
    input wire logic        stk_push,
    input wire logic        stk_pop,
    input wire logic        stk_call,
    input wire logic        stk_ret,
    input wire logic [7:0]  program_store_control,
    // watched outputs
    input wire logic        code_valid,
    input wire logic        code_reserved,
    input wire logic        code_write,
    input wire logic [7:0]  ram_addr,
    input wire logic        ram_sel,
    input wire logic [2:0]  ram_bit,
    input wire logic        ram_bit_mode,
    input wire logic        sfr_sel,
    input wire logic [7:0]  stack_top_pointer,
    input wire logic [7:0]  stack_wr_addr,
    input wire logic        auto_page_enable
);
    localparam logic [15:0] TOP = LARGE_FLASH ? MSP_FLASH_TOP_LARGE
                                              : MSP_FLASH_TOP_SMALL;
    wire logic sp_wr = data_wr && !data_indirect && !data_bit
                       && data_addr == MSP_ADDR_SP;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sp_reset_a: assert property ($fell(reset) |->
        stack_top_pointer == MSP_SP_RESET && auto_page_enable)
        else $error("pointer or auto enable wrong after reset");
    push_step_a: assert property (stk_push && !stk_pop && !stk_call
        && !stk_ret && !sp_wr |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01)
        else $error("push did not advance pointer by one");
    push_addr_a: assert property (stack_wr_addr == stack_top_pointer + 8'h01)
        else $error("push address not pointer plus one");
    direct_sfr_a: assert property (!data_indirect && data_addr[7] |-> sfr_sel && !ram_sel)
        else $error("direct high access not to special registers");
    indirect_ram_a: assert property (data_indirect && !data_bit |-> ram_sel && !sfr_sel
        && ram_addr == (data_use_r1 ? reg_r1 : reg_r0))
        else $error("indirect access decoded wrongly");
    bit_ram_a: assert property (data_bit && !data_indirect && !data_addr[7] |->
        ram_bit_mode && ram_sel && ram_bit == data_addr[2:0]
        && ram_addr == MSP_BITRAM_BASE + {4'h0, data_addr[6:3]})
        else $error("bit address mapped wrongly");
    flash_map_a: assert property (code_fetch |-> code_valid == (code_addr <= TOP)
        && code_reserved == (code_addr > TOP))
        else $error("flash range decoded wrongly");
    code_wr_a: assert property (xdata_wr && code_addr <= TOP |->
        code_write == program_store_control[MSP_PSWE_BIT])
        else $error("store enable not steering writes");
    code_ro_a: assert property (!xdata_wr |-> !code_write)
        else $error("code write without data move");
endmodule
bind msp_memmap msp_memmap_checker #(.LARGE_FLASH(LARGE_FLASH)) chk_u (
    .clk, .reset, .code_addr, .code_fetch, .xdata_wr, .data_addr,
    .data_indirect, .data_use_r1, .data_bit, .data_wr, .reg_r0, .reg_r1,
    .stk_push, .stk_pop, .stk_call, .stk_ret, .program_store_control,
    .code_valid, .code_reserved, .code_write, .ram_addr, .ram_sel, .ram_bit,
    .ram_bit_mode, .sfr_sel, .stack_top_pointer, .stack_wr_addr,
    .auto_page_enable);
`default_nettype wire

// [testbench/msp_core_model.sv]
// Purpose: core side model giving interrupt strobes
// Assumes: bench holds a request level one cycle or more
// Notes:   each request gives exactly one strobe
`timescale 1ns/1ps
`default_nettype none
module msp_core_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // bench requests
    input  wire logic go_entry,
    input  wire logic go_return,
    // strobes to the block
    output logic      irq_entry,
    output logic      irq_return
);
    logic go_entry_reg;
    logic go_return_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            go_entry_reg  <= 1'b0;
            go_return_reg <= 1'b0;
        end else begin
            go_entry_reg  <= go_entry;
            go_return_reg <= go_return;
        end
    end
    assign irq_entry  = go_entry && !go_entry_reg;
    assign irq_return = go_return && !go_return_reg;
endmodule
`default_nettype wire

// [testbench/msp_memmap_tb.sv]
// Purpose: self-checking bench for the memory map block
// Assumes: large flash build
// Notes:   interrupt strobes come from the core model
`timescale 1ns/1ps
`default_nettype none
module msp_memmap_tb
    import msp_pkg::*;
;
    logic        clk, reset, code_fetch, xdata_wr, data_indirect, data_use_r1;
    logic        data_bit, data_wr, stk_push, stk_pop, stk_call, stk_ret;
    logic        go_entry, go_return, irq_entry, irq_return, code_valid;
    logic        code_reserved, code_write, ram_sel, ram_bit_mode, sfr_sel;
    logic        sfr_bit_mode, bit_illegal, local_hit, rec_overflow;
    logic        rec_underflow, auto_page_enable, e_en;
    logic [15:0] code_addr;
    logic [7:0]  data_addr, data_wdata, reg_r0, reg_r1, ram_addr, sfr_addr;
    logic [7:0]  sfr_page, local_rdata, stack_top_pointer, stack_wr_addr;
    logic [7:0]  program_status_word, program_store_control, v;
    logic [7:0]  e_sel, e_sec, e_bot, e_sp;
    logic [2:0]  ram_bit;
    logic [31:0] rec_shift;
    int          n_mismatch = 0, cmp_count = 0, cycles = 0, r;
    logic [15:0] caddr [6] = '{16'h0000, 16'h3fff, 16'h4000, 16'h7bff,
                               16'h7c00, 16'hffff};
    logic [7:0]  ports [4] = '{8'h80, 8'h90, 8'ha0, 8'hb0};
    msp_memmap #(.LARGE_FLASH(1'b1)) dut_u (
        .clk, .reset, .code_addr, .code_fetch, .xdata_wr, .code_valid,
        .code_reserved, .code_write, .data_addr, .data_indirect,
        .data_use_r1, .data_bit, .data_wr, .data_wdata, .reg_r0, .reg_r1,
        .ram_addr, .ram_sel, .ram_bit, .ram_bit_mode, .sfr_sel, .sfr_addr,
        .sfr_page, .sfr_bit_mode, .bit_illegal, .local_rdata, .local_hit,
        .stk_push, .stk_pop, .stk_call, .stk_ret, .stack_top_pointer,
        .stack_wr_addr, .rec_shift, .rec_overflow, .rec_underflow,
        .irq_entry, .irq_return, .program_status_word,
        .program_store_control, .auto_page_enable);
    msp_core_model core_u (.clk, .reset, .go_entry, .go_return,
                           .irq_entry, .irq_return);
    initial clk = 1'b0;
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic do_reset();
        reset = 1'b1;
        repeat (4) @(posedge clk);
        #1 reset = 1'b0;
        {e_sel, e_sec, e_bot, e_en, e_sp} = {24'h0, 1'b1, MSP_SP_RESET};
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {data_addr, data_wdata, data_indirect, data_bit} = {a, d, 2'b00};
        data_wr = 1'b1;
        step();
        data_wr = 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        {data_addr, data_indirect, data_bit} = {a, 2'b00};
        #5 chk(local_rdata, exp);
        chk(local_hit, 1'b1);
    endtask
    task automatic chk_stack();
        rdchk(MSP_ADDR_PAGE_SEL, e_sel);
        rdchk(MSP_ADDR_PAGE_SEC, e_sec);
        rdchk(MSP_ADDR_PAGE_BOT, e_bot);
    endtask
    // expected page stack move, then one strobe
    task automatic irq(input bit ret);
        if (e_en && ret) {e_sel, e_sec, e_bot} = {e_sec, e_bot, 8'h00};
        if (e_en && !ret) {e_sel, e_sec, e_bot} = {8'h00, e_sel, e_sec};
        {go_entry, go_return} = {!ret, ret};
        step();
        {go_entry, go_return} = 2'b00;
        step();
    endtask
    // stack event: 0 push, 1 pop, 2 call, 3 return, 4 none
    task automatic ev(input int k);
        {stk_push, stk_pop, stk_call, stk_ret} = 4'b1000 >> k;
        step();
    endtask
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        {code_fetch, xdata_wr, data_indirect, data_use_r1, data_bit} = '0;
        {data_wr, stk_push, stk_pop, stk_call, stk_ret, go_entry} = '0;
        {go_return, code_addr, data_addr, data_wdata, reg_r0} = '0;
        {reg_r1, program_status_word, program_store_control} = '0;
        r = $urandom(32'hecce84db);
        do_reset();
        chk(stack_top_pointer, MSP_SP_RESET);
        chk(auto_page_enable, 1'b1);
        chk_stack();
        wr(MSP_ADDR_PAGE_SEL, MSP_PAGE_F);
        e_sel = MSP_PAGE_F;
        rdchk(MSP_ADDR_PAGE_CTL, MSP_PAGE_CTL_RESET);
        for (int k = 0; k < 4; k++) begin
            data_addr = ports[k];
            #5 chk({sfr_sel, sfr_page}, {1'b1, MSP_PAGE_0});
        end
        data_addr = 8'hb6;
        #5 chk(sfr_page, MSP_PAGE_F);
        {data_bit, data_addr} = {1'b1, 8'h93};
        #5 chk({sfr_addr, sfr_bit_mode, bit_illegal}, {8'h90, 2'b10});
        irq(0);
        chk_stack();
        irq(0);
        chk_stack();
        irq(1);
        chk_stack();
        for (int k = 0; k < 40; k++) begin
            r = $urandom_range(0, 3);
            v = 8'($urandom);
            if (r < 2) irq(r[0]);
            if (r == 2) {e_sel, v} = {v, MSP_ADDR_PAGE_SEL};
            if (r == 3) {e_sec, v} = {v, MSP_ADDR_PAGE_SEC};
            if (r > 1) wr(v, r == 2 ? e_sel : e_sec);
            chk_stack();
        end
        wr(MSP_ADDR_PAGE_SEL, MSP_PAGE_0);
        wr(MSP_ADDR_PAGE_CTL, 8'h00);
        chk(auto_page_enable, 1'b1);
        wr(MSP_ADDR_PAGE_SEL, MSP_PAGE_F);
        wr(MSP_ADDR_PAGE_CTL, 8'h00);
        {e_sel, e_en} = {MSP_PAGE_F, 1'b0};
        chk(auto_page_enable, 1'b0);
        irq(0);
        irq(1);
        chk_stack();
        for (int k = 0; k < 16; k++) begin
            r = $urandom_range(0, 2);
            v = 8'($urandom);
            if (r == 2) wr(MSP_ADDR_SP, v);
            else ev(r);
            ev(4);
            e_sp = r == 2 ? v : r == 0 ? e_sp + 8'h01 : e_sp - 8'h01;
            chk(stack_top_pointer, e_sp);
        end
        do_reset();
        repeat (16) ev(2);
        ev(4);
        chk({rec_overflow, 6'($countones(rec_shift))}, 7'd32);
        ev(0);
        ev(4);
        chk(rec_overflow, 1'b1);
        do_reset();
        ev(2);
        ev(0);
        ev(4);
        chk($countones(rec_shift), 2);
        ev(1);
        ev(3);
        ev(4);
        chk({rec_shift, rec_underflow}, 33'h0);
        ev(1);
        ev(4);
        chk(rec_underflow, 1'b1);
        for (int k = 0; k < 40; k++) begin
            {data_addr, reg_r0, reg_r1, program_status_word} = $urandom;
            {data_indirect, data_use_r1, data_bit} = 3'($urandom);
            data_bit = data_bit && !data_indirect;
            #5;
            if (data_indirect) chk(ram_addr, data_use_r1 ? reg_r1 : reg_r0);
            else if (data_addr[7]) chk(sfr_sel, 1'b1);
            else if (data_bit) chk({ram_addr, ram_bit}, {4'h2, data_addr[6:0]});
            else if (data_addr < 8'h20) chk(ram_addr, {3'h0, program_status_word[4:3], data_addr[2:0]});
            step();
        end
        for (int k = 0; k < 6; k++) begin
            {code_addr, code_fetch, xdata_wr} = {caddr[k], 2'b11};
            program_store_control = 8'(k % 2);
            #5 chk({code_valid, code_reserved}, {caddr[k] <= 16'h7bff, caddr[k] > 16'h7bff});
            if (k < 4) chk(code_write, k % 2);
            step();
        end
        stop_test();
    end
endmodule
`default_nettype wire
